/* File: strap_ctrl_pkg.sv */
// Constants and carrier types shared by the dual UART strap and reset control.
// Assumes a single 100 MHz clock; every pin input is resynchronised before use.

package strap_ctrl_pkg;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int MODEM_CTRL_OUT2_BIT = 3;
  localparam int MODEM_CTRL_PRESCALE_BIT = 7;
  localparam int MODEM_CTRL_WIDTH = 8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_MIN_NS = 40;
  // Least time, so round up to whole cycles
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W = 3;
  localparam logic [RESET_CNT_W-1:0] RESET_CNT_LAST = RESET_CNT_W'(RESET_MIN_CYC - 1);
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic DEV_RESET_INIT = 1'b1;
  localparam logic MCR_OUT2_INIT = 1'b0;
  localparam logic DIV4_INIT = 1'b0;
  localparam logic TX_IDLE = 1'b1;
  localparam logic RX_IDLE = 1'b1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic
  {
    MODE_DIRECTION = 1'b0,
    MODE_STROBE = 1'b1
  } bus_mode_type;

  // Raw host control pins, all active low except a3 and rw_n high-read
  typedef struct packed
  {
    logic rd_n;
    logic wr_n;
    logic cs_a_n;
    logic cs_b_n;
    logic cs_n;
    logic rw_n;
    logic a3;
  } host_pins_type;

  // Decoded per-channel access levels
  typedef struct packed
  {
    logic rd_a;
    logic wr_a;
    logic rd_b;
    logic wr_b;
  } access_type;

endpackage : strap_ctrl_pkg

/* File: pin_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= INIT;
      synced <= INIT;
    end
    else
    begin
      meta_q <= raw;
      synced <= meta_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

/* File: strap_reset_control.sv */
// Strap, reset-pin and channel B auxiliary pin control of a dual UART.
// Assumes pins arrive asynchronously; control writes come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module strap_reset_control (
  // Clock and system reset
  input wire logic clk,
  input wire logic rst,
  // Straps and device pins
  input wire logic bus_style_sel,
  input wire logic reset_pin,
  input wire logic prescale_strap,
  input wire logic bus_isolate_sleep,
  input wire logic ring_indicator_b_n,
  input wire strap_ctrl_pkg::host_pins_type host_pins,
  input wire logic [1:0] rx_pin,
  // Serial engine side
  input wire logic [1:0] tx_data,
  input wire logic irq_req_b,
  // Control register writes, index 0 channel A, 1 channel B
  input wire logic [1:0] modem_ctrl_wr,
  input wire logic [strap_ctrl_pkg::MODEM_CTRL_WIDTH-1:0] modem_ctrl_wdata,
  // Device state
  output strap_ctrl_pkg::bus_mode_type bus_mode_q,
  output logic dev_reset_q,
  output strap_ctrl_pkg::access_type access_q,
  output logic [1:0] div4_q,
  output logic [1:0] baud_en_q,
  output logic ri_active_q,
  // Serial pins
  output logic [1:0] tx_pin_q,
  output logic [1:0] rx_data_q,
  // Channel B interrupt and auxiliary pins
  output logic irq_out_b_q,
  output logic irq_out_b_oe_n_q,
  output logic aux_output_b_n_q
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic style_s;
  logic reset_s;
  logic strap_s;
  logic iso_s;
  logic ri_n_s;
  logic [1:0] rx_s;
  strap_ctrl_pkg::host_pins_type host_s;

  pin_sync #(.WIDTH(7), .INIT(7'h7F)) u_sync_pins (
    .clk(clk),
    .rst(rst),
    .raw({bus_style_sel, reset_pin, prescale_strap, bus_isolate_sleep, ring_indicator_b_n, rx_pin}),
    .synced({style_s, reset_s, strap_s, iso_s, ri_n_s, rx_s})
  );

  // Idle host pins: all strobes and selects high
  pin_sync #(.WIDTH($bits(strap_ctrl_pkg::host_pins_type)), .INIT(7'h7E)) u_sync_host (
    .clk(clk),
    .rst(rst),
    .raw(host_pins),
    .synced(host_s)
  );

  // ****************************************************************
  // Bus style and reset pin
  // ****************************************************************
  logic reset_active;
  logic [strap_ctrl_pkg::RESET_CNT_W-1:0] reset_cnt_q;

  // Polarity of the reset pin follows the style strap
  assign reset_active = style_s ? reset_s : !reset_s;

  // Style strap followed continuously
  always_ff @(posedge clk)
  begin
    if (rst)
      bus_mode_q <= strap_ctrl_pkg::MODE_STROBE;
    else
      bus_mode_q <= style_s ? strap_ctrl_pkg::MODE_STROBE : strap_ctrl_pkg::MODE_DIRECTION;
  end

  // Pulse width filter: shorter glitches do not reset the part
  always_ff @(posedge clk)
  begin
    if (rst || !reset_active)
      reset_cnt_q <= '0;
    else if (reset_cnt_q != strap_ctrl_pkg::RESET_CNT_LAST)
      reset_cnt_q <= reset_cnt_q + 1'b1;
  end

  // Device reset entered after the filter, then held while the pin stays active.
  // Out of rst the synchronisers still show their reset level, so holding here
  // keeps the strap capture open until real pin levels have arrived.
  always_ff @(posedge clk)
  begin
    if (rst)
      dev_reset_q <= strap_ctrl_pkg::DEV_RESET_INIT;
    else
      dev_reset_q <= reset_active && (dev_reset_q || (reset_cnt_q == strap_ctrl_pkg::RESET_CNT_LAST));
  end

  // ****************************************************************
  // Host access decode
  // ****************************************************************
  // Levels only; the bus cycle engine samples these against its own timing
  always_ff @(posedge clk)
  begin
    if (rst || dev_reset_q || iso_s)
      access_q <= '0;
    else if (bus_mode_q == strap_ctrl_pkg::MODE_STROBE)
    begin
      // Both selects low writes both channels at once
      access_q.rd_a <= !host_s.rd_n && !host_s.cs_a_n;
      access_q.wr_a <= !host_s.wr_n && !host_s.cs_a_n;
      access_q.rd_b <= !host_s.rd_n && !host_s.cs_b_n;
      access_q.wr_b <= !host_s.wr_n && !host_s.cs_b_n;
    end
    else
    begin
      // Address line picks the channel in this mode
      access_q.rd_a <= !host_s.cs_n && host_s.rw_n && !host_s.a3;
      access_q.wr_a <= !host_s.cs_n && !host_s.rw_n && !host_s.a3;
      access_q.rd_b <= !host_s.cs_n && host_s.rw_n && host_s.a3;
      access_q.wr_b <= !host_s.cs_n && !host_s.rw_n && host_s.a3;
    end
  end

  // ****************************************************************
  // Prescaler selection and baud enables
  // ****************************************************************
  logic [1:0] div_cnt_q;

  // Strap caught while reset stands; later only software changes it
  always_ff @(posedge clk)
  begin
    if (rst)
      div4_q <= {2{strap_ctrl_pkg::DIV4_INIT}};
    else if (dev_reset_q)
      div4_q <= {2{!strap_s}};
    else
    begin
      for (int ch = 0; ch < 2; ch++)
      begin
        if (modem_ctrl_wr[ch])
          div4_q[ch] <= modem_ctrl_wdata[strap_ctrl_pkg::MODEM_CTRL_PRESCALE_BIT];
      end
    end
  end

  // Shared free-running divide-by-four phase
  always_ff @(posedge clk)
  begin
    if (rst || dev_reset_q)
      div_cnt_q <= '0;
    else
      div_cnt_q <= div_cnt_q + 1'b1;
  end

  // One-cycle enables toward each baud generator
  always_ff @(posedge clk)
  begin
    if (rst || dev_reset_q)
      baud_en_q <= '0;
    else
    begin
      for (int ch = 0; ch < 2; ch++)
        baud_en_q[ch] <= !div4_q[ch] || (div_cnt_q == strap_ctrl_pkg::DIV4_LAST);
    end
  end

  // ****************************************************************
  // Channel B output 2, interrupt and ring input
  // ****************************************************************
  logic out2_b_q;

  // Only channel B has these pins here
  always_ff @(posedge clk)
  begin
    if (rst || dev_reset_q)
      out2_b_q <= strap_ctrl_pkg::MCR_OUT2_INIT;
    else if (modem_ctrl_wr[1])
      out2_b_q <= modem_ctrl_wdata[strap_ctrl_pkg::MODEM_CTRL_OUT2_BIT];
  end

  // Aux pin and interrupt enable share one bit, so aux is not free while the interrupt is used
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_out_b_oe_n_q <= 1'b1;
      aux_output_b_n_q <= 1'b1;
      irq_out_b_q <= 1'b0;
    end
    else
    begin
      irq_out_b_oe_n_q <= !out2_b_q;
      aux_output_b_n_q <= !out2_b_q;
      irq_out_b_q <= irq_req_b && !dev_reset_q;
    end
  end

  // Ring input is a status bit only; nothing else reads it
  always_ff @(posedge clk)
  begin
    if (rst || dev_reset_q)
      ri_active_q <= 1'b0;
    else
      ri_active_q <= !ri_n_s;
  end

  // ****************************************************************
  // Serial pins
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst || dev_reset_q)
    begin
      tx_pin_q <= {2{strap_ctrl_pkg::TX_IDLE}};
      rx_data_q <= {2{strap_ctrl_pkg::RX_IDLE}};
    end
    else
    begin
      tx_pin_q <= tx_data;
      rx_data_q <= rx_s;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  ring_status_only_a: assert property (@(posedge clk) disable iff (rst)
    !dev_reset_q && !$past(dev_reset_q) |-> ri_active_q == !$past(ri_n_s))
    else $error("ring status does not follow ring input");

  irq_drive_on_a: assert property (@(posedge clk) disable iff (rst)
    out2_b_q |=> !irq_out_b_oe_n_q && !aux_output_b_n_q)
    else $error("interrupt not driven or aux not low");

  irq_float_off_a: assert property (@(posedge clk) disable iff (rst)
    !out2_b_q |=> irq_out_b_oe_n_q && aux_output_b_n_q)
    else $error("interrupt not floated or aux not high");

  bus_isolate_block_a: assert property (@(posedge clk) disable iff (rst)
    iso_s |=> access_q == '0)
    else $error("host access passed during isolation");

  strobe_mode_decode_a: assert property (@(posedge clk) disable iff (rst)
    bus_mode_q == strap_ctrl_pkg::MODE_STROBE && !iso_s && !dev_reset_q
    |=> access_q.wr_b == (!$past(host_s.wr_n) && !$past(host_s.cs_b_n)))
    else $error("strobe mode write decode wrong");

  dir_mode_decode_a: assert property (@(posedge clk) disable iff (rst)
    bus_mode_q == strap_ctrl_pkg::MODE_DIRECTION && !iso_s && !dev_reset_q
    |=> access_q.rd_a == (!$past(host_s.cs_n) && $past(host_s.rw_n) && !$past(host_s.a3)))
    else $error("direction mode read decode wrong");

  strap_ignored_run_a: assert property (@(posedge clk) disable iff (rst)
    !dev_reset_q && modem_ctrl_wr == 2'h0 |=> $stable(div4_q))
    else $error("prescaler changed without reset or write");

  strap_load_a: assert property (@(posedge clk) disable iff (rst)
    dev_reset_q |=> div4_q == {2{!$past(strap_s)}})
    else $error("strap not loaded during reset");

  div1_every_cycle_a: assert property (@(posedge clk) disable iff (rst)
    !div4_q[0] && !dev_reset_q |=> baud_en_q[0])
    else $error("divide by one missed an enable");

  div4_spacing_a: assert property (@(posedge clk) disable iff (rst || dev_reset_q)
    div4_q[1] && $past(div4_q[1]) && baud_en_q[1] |-> !$past(baud_en_q[1]))
    else $error("divide by four enables too close");

  prescale_override_a: assert property (@(posedge clk) disable iff (rst)
    !dev_reset_q && modem_ctrl_wr[1] |=> div4_q[1] == $past(modem_ctrl_wdata[strap_ctrl_pkg::MODEM_CTRL_PRESCALE_BIT]))
    else $error("software prescaler write not taken");

  reset_filter_a: assert property (@(posedge clk) disable iff (rst)
    reset_active && reset_cnt_q == strap_ctrl_pkg::RESET_CNT_LAST |=> dev_reset_q)
    else $error("reset pin active long enough but no reset");

  reset_release_a: assert property (@(posedge clk) disable iff (rst)
    !reset_active |=> !dev_reset_q)
    else $error("device reset without active pin");

  reset_clears_out2_a: assert property (@(posedge clk) disable iff (rst)
    dev_reset_q |=> !out2_b_q ##1 aux_output_b_n_q)
    else $error("reset did not restore output 2");

  tx_high_reset_a: assert property (@(posedge clk) disable iff (rst)
    dev_reset_q |=> tx_pin_q == 2'h3 && rx_data_q == 2'h3)
    else $error("serial pins not idle during reset");

endmodule : strap_reset_control

`default_nettype wire

/* File: host_bus_model.sv */
// Host processor model that drives the parallel bus control pins.
// Assumes op and chan come from the bench on clk; op 0 idle, 1 read, 2 write.
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  // Clock
  input wire logic clk,
  // Commands, chan bit0 channel A, bit1 channel B; in direction mode bit1 alone picks B over A
  input wire strap_ctrl_pkg::bus_mode_type mode,
  input wire logic [1:0] op,
  input wire logic [1:0] chan,
  // Bus pins
  output strap_ctrl_pkg::host_pins_type pins
);
  // ****************************************************************
  // Pin driver
  // ****************************************************************
  strap_ctrl_pkg::host_pins_type pins_q = '1;
  logic flip_q = 1'b0;
  assign pins = pins_q;

  // Lines unused by the mode toggle, so a stale level cannot pass for a decode
  always_ff @(posedge clk)
  begin
    flip_q <= !flip_q;
    if (mode == strap_ctrl_pkg::MODE_STROBE)
      pins_q <= '{rd_n: op != 2'h1, wr_n: op != 2'h2, cs_a_n: !chan[0] || op == 2'h0,
        cs_b_n: !chan[1] || op == 2'h0, cs_n: flip_q, rw_n: !flip_q, a3: flip_q};
    else
      pins_q <= '{rd_n: flip_q, wr_n: !flip_q, cs_a_n: flip_q, cs_b_n: !flip_q, cs_n: op == 2'h0,
        rw_n: op == 2'h0 ? flip_q : op == 2'h1, a3: op == 2'h0 ? !flip_q : chan[1]};
  end
endmodule : host_bus_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the strap and reset control block.
// Assumes host_bus_model drives the bus pins; all other pins come from here.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic style = 1'b1;
  logic rpin = 1'b0;
  logic strap = 1'b0;
  logic iso = 1'b0;
  logic ring_n = 1'b1;
  logic [1:0] rx = 2'h0;
  logic [1:0] txd = 2'h0;
  logic irqr = 1'b0;
  logic [1:0] modem_ctrl_wr = 2'h0;
  logic [7:0] modem_ctrl_wdata = 8'h00;
  logic [1:0] op = 2'h0;
  logic [1:0] chan = 2'h0;
  strap_ctrl_pkg::host_pins_type hp;
  strap_ctrl_pkg::bus_mode_type bus_mode_q;
  strap_ctrl_pkg::access_type access_q;
  logic dev_reset_q, ri_active_q, irq_out_b_q, irq_out_b_oe_n_q, aux_output_b_n_q;
  logic [1:0] div4_q, baud_en_q, tx_pin_q, rx_data_q;
  logic [1:0] div4_m;
  int fail_count = 0;
  int checks = 0;
  int seed = 32'h1A591FD6;
  logic [1:0] top [10] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h0};
  logic [1:0] tch [10] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1};

  always #5 clk = !clk;

  strap_reset_control uut (.clk(clk), .rst(rst), .bus_style_sel(style), .reset_pin(rpin),
    .prescale_strap(strap), .bus_isolate_sleep(iso), .ring_indicator_b_n(ring_n), .host_pins(hp),
    .rx_pin(rx), .tx_data(txd), .irq_req_b(irqr), .modem_ctrl_wr(modem_ctrl_wr),
    .modem_ctrl_wdata(modem_ctrl_wdata),
    .bus_mode_q(bus_mode_q), .dev_reset_q(dev_reset_q), .access_q(access_q), .div4_q(div4_q),
    .baud_en_q(baud_en_q), .ri_active_q(ri_active_q), .tx_pin_q(tx_pin_q), .rx_data_q(rx_data_q),
    .irq_out_b_q(irq_out_b_q), .irq_out_b_oe_n_q(irq_out_b_oe_n_q), .aux_output_b_n_q(aux_output_b_n_q));

  host_bus_model host (.clk(clk), .mode(strap_ctrl_pkg::bus_mode_type'(style)), .op(op), .chan(chan), .pins(hp));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Sample at the falling edge, once the rising edge's updates have landed
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt

  // One-cycle control write, taken at the second rising edge
  task automatic ctrl_write(input int ch, input logic [7:0] d);
    @(posedge clk);
    modem_ctrl_wr <= 2'h1 << ch;
    modem_ctrl_wdata <= d;
    @(posedge clk);
    modem_ctrl_wr <= 2'h0;
    div4_m[ch] = d[strap_ctrl_pkg::MODEM_CTRL_PRESCALE_BIT];
    wt(4);
  endtask : ctrl_write

  // Pulses over 16 cycles: 16 when dividing by one, 4 when dividing by four
  task automatic baud_chk;
    int n [2];
    n = '{0, 0};
    repeat (16)
    begin
      wt(1);
      for (int c = 0; c < 2; c++)
        n[c] += (baud_en_q[c] === 1'b1);
    end
    for (int c = 0; c < 2; c++)
      chk("baud_en", 8'(n[c]), div4_m[c] ? 8'h04 : 8'h10);
  endtask : baud_chk

  function automatic strap_ctrl_pkg::access_type acc_exp(input logic m, input logic [1:0] o,
    input logic [1:0] c, input logic i);
    logic a0;
    a0 = m ? c[0] : !c[1];
    if (i || o == 2'h0)
      return '0;
    return '{rd_a: o == 2'h1 && a0, wr_a: o == 2'h2 && a0, rd_b: o == 2'h1 && c[1], wr_b: o == 2'h2 && c[1]};
  endfunction : acc_exp

  // Hang guard, far above the few hundred cycles the sequence needs
  initial
  begin
    #200000;
    fail_count++;
    close_out();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    wt(5);
    chk("tx_in_reset", tx_pin_q, 2'h3);
    chk("rx_in_reset", rx_data_q, 2'h3);
    chk("oe_n_reset", {irq_out_b_oe_n_q, aux_output_b_n_q, access_q}, 8'h30);
    @(posedge clk);
    rst <= 1'b0;
    div4_m = 2'h3;
    wt(10);
    chk("dev_reset", dev_reset_q, 1'b0);
    chk("div4", div4_q, div4_m);
    @(posedge clk);
    strap <= 1'b1;
    wt(8);
    chk("div4_late_strap", div4_q, div4_m);
    baud_chk();
    ctrl_write(0, 8'h08);
    chk("div4_write", div4_q, div4_m);
    chk("a_bit3_ignored", irq_out_b_oe_n_q, 1'b1);
    baud_chk();
    // Aux B is never used as a free output here, only with the enable
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      irqr <= 1'($random(seed));
      ctrl_write(1, k[0] ? 8'h80 : 8'h08);
      chk("irq_oe_n", irq_out_b_oe_n_q, k[0]);
      chk("aux_b", aux_output_b_n_q, k[0]);
      if (!k[0])
        chk("irq_b", irq_out_b_q, irqr);
      chk("div4_b", div4_q, div4_m);
    end
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      txd <= 2'($random(seed));
      rx <= 2'($random(seed));
      ring_n <= 1'($random(seed));
      wt(4);
      chk("tx", tx_pin_q, txd);
      chk("rx", rx_data_q, rx);
      chk("ring", ri_active_q, !ring_n);
      chk("ring_no_effect", {div4_q, irq_out_b_oe_n_q, dev_reset_q}, {div4_m, 2'h2});
    end
    for (int k = 0; k < 11; k++)
    begin
      @(posedge clk);
      style <= (k < 5);
      rpin <= (k >= 5);
      op <= top[k % 10];
      chan <= tch[k % 10];
      iso <= (k == 10);
      wt(8);
      chk("bus_mode", bus_mode_q, style);
      chk("access", access_q, acc_exp(style, op, chan, iso));
    end
    ctrl_write(1, 8'h88);
    @(posedge clk);
    iso <= 1'b0;
    op <= 2'h1;
    rpin <= 1'b0;
    repeat (2) @(posedge clk);
    rpin <= 1'b1;
    wt(8);
    chk("short_pulse", dev_reset_q, 1'b0);
    @(posedge clk);
    rpin <= 1'b0;
    wt(12);
    chk("pin_reset", {dev_reset_q, baud_en_q, tx_pin_q, rx_data_q}, 8'h4F);
    chk("pin_reset_out", {access_q, irq_out_b_oe_n_q, aux_output_b_n_q, ri_active_q, irq_out_b_q}, 8'h0C);
    @(posedge clk);
    rpin <= 1'b1;
    div4_m = 2'h0;
    wt(8);
    chk("div4_reload", {dev_reset_q, div4_q}, {1'b0, div4_m});
    @(posedge clk);
    style <= 1'b1;
    wt(12);
    chk("high_reset", dev_reset_q, 1'b1);
    close_out();
  end
endmodule : testbench
`default_nettype wire
